// *** src/usb_port1_ready_irq_regs.svh ***
`ifndef USB_PORT1_READY_IRQ_REGS_SVH
`define USB_PORT1_READY_IRQ_REGS_SVH

`define ADDR_W 8
`define DATA_W 16
`define PIPE_COUNT 10

`define OFS_PORT_STATUS 8'h04
`define OFS_PIPE_MODE 8'h06
`define OFS_PORT_IRQ_EN 8'h34
`define OFS_BUFFER_READY_EN 8'h36
`define OFS_MAIN_IRQ 8'h40
`define OFS_PORT_IRQ 8'h44
`define OFS_BUFFER_READY_STS 8'h46
`define OFS_PIPE_DIR 8'h50
`define OFS_END_MODE 8'h52
`define OFS_AUTO_CLR 8'h54

`define BIT_OVRC 15
`define BIT_BUS_CHANGE_FLAG 14
`define BIT_DETACH_FLAG 12
`define BIT_ATTACH 11
`define BIT_EOF 6
`define PORT_IRQ_MASK 16'hD840

`define PS_LINE_LO 0
`define PS_OCMON 2
`define PS_ACTIVE 4
`define PS_HOST 5
`define PS_CLOCK_SUPPLY_ENABLE 10
`define MODE_READY_FLAG 0

`define MAIN_PORT_BIT 0
`define MAIN_BUFFER_READY_BIT 8

`define LS_SE0 2'h0
`define LS_J 2'h1
`define LS_K 2'h2
`define LS_SE1 2'h3

`define RESET_WORD 16'h0000
`define RESET_PIPES 10'h000

`define CLK_PERIOD_NS 40
`define ATTACH_HOLD_NS 2500
`define ATTACH_HOLD_CYC ((`ATTACH_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ATT_CNT_W 7

`endif

// *** src/usb_irq_pkg.sv ***
`include "usb_port1_ready_irq_regs.svh"

package usb_irq_pkg;

	typedef enum logic [1:0]
	{
		ATT_IDLE = 2'h0,
		ATT_HOLD = 2'h1,
		ATT_DONE = 2'h3
	} attach_state_t;

	typedef logic [`PIPE_COUNT-1:0] pipe_vec_t;

	typedef struct packed
	{
		logic [`DATA_W-1:0] port_irq_reg;
		logic [`DATA_W-1:0] port_en_reg;
		pipe_vec_t buffer_ready_reg;
		pipe_vec_t buffer_ready_en_reg;
		pipe_vec_t dir_reg;
		pipe_vec_t end_mode_reg;
		pipe_vec_t auto_clr_reg;
		logic ready_mode_reg;
		logic port_active_reg;
		logic host_mode_reg;
		logic clock_supply_enable_reg;
		logic oc_prev_reg;
		logic [1:0] line_prev_reg;
		attach_state_t att_state_reg;
		logic [`ATT_CNT_W-1:0] att_cnt_reg;
		logic [`DATA_W-1:0] rdata_reg;
		logic irq_b_reg;
		logic idle_pulse_reg;
	} core_state_t;

	typedef struct packed
	{
		pipe_vec_t trig_reg;
		pipe_vec_t dir_prev_reg;
		pipe_vec_t acl_prev_reg;
	} trig_state_t;

endpackage

// *** src/ready_trig_if.sv ***
`timescale 1ns/1ps

interface ready_trig_if #(parameter int PIPES = 10);
	logic [PIPES-1:0] dir;
	logic [PIPES-1:0] end_mode;
	logic [PIPES-1:0] auto_clr;
	logic [PIPES-1:0] access_ok;
	logic [PIPES-1:0] tx_done;
	logic [PIPES-1:0] rx_done;
	logic [PIPES-1:0] short_pkt;
	logic [PIPES-1:0] cnt_done;
	logic [PIPES-1:0] pid_mismatch;
	logic [PIPES-1:0] dbl;
	logic [PIPES-1:0] iso;
	logic [PIPES-1:0] iso_flush;
	logic [PIPES-1:0] wr_side_done;
	logic [PIPES-1:0] other_empty;
	logic [PIPES-1:0] rd_side_done;
	logic [PIPES-1:0] other_ready;
	logic ready_mode;
	logic status_stage;
	logic [PIPES-1:0] trig;

	modport core (output dir, end_mode, auto_clr, access_ok, tx_done, rx_done, short_pkt, cnt_done,
		pid_mismatch, dbl, iso, iso_flush, wr_side_done, other_empty, rd_side_done, other_ready,
		ready_mode, status_stage, input trig);
	modport qual (input dir, end_mode, auto_clr, access_ok, tx_done, rx_done, short_pkt, cnt_done,
		pid_mismatch, dbl, iso, iso_flush, wr_side_done, other_empty, rd_side_done, other_ready,
		ready_mode, status_stage, output trig);
endinterface

// *** src/ready_trigger.sv ***
`timescale 1ns/1ps

module ready_trigger
	import usb_irq_pkg::*;
#(
	parameter int PIPES = 10
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	ready_trig_if.qual rt
);
	logic [PIPES-1:0] hit;
	trig_state_t s;
	trig_state_t n;

	genvar i;
	generate
		for (i = 0; i < PIPES; i++)
		begin : g_pipe
			logic dir_rise;
			logic acl_rise;
			logic tx_hit;
			logic rx_hit;
			logic blocked;
			assign dir_rise = rt.dir[i] & ~s.dir_prev_reg[i];
			// auto clear taking the buffer from write-disabled to write-enabled
			assign acl_rise = rt.auto_clr[i] & ~s.acl_prev_reg[i] & ~rt.access_ok[i];
			assign tx_hit = dir_rise
				| (rt.tx_done[i] & ~rt.access_ok[i])
				| (rt.dbl[i] & rt.wr_side_done[i] & rt.other_empty[i])
				| (rt.iso[i] & rt.iso_flush[i])
				| acl_rise;
			assign rx_hit = (rt.rx_done[i] & ~rt.pid_mismatch[i]
				& (~rt.access_ok[i] | rt.short_pkt[i] | rt.cnt_done[i]))
				| (rt.dbl[i] & rt.rd_side_done[i] & rt.other_ready[i]);
			// only the accessibility mode raises triggers here
			assign blocked = rt.ready_mode | rt.end_mode[i] | rt.status_stage;
			if (i == 0)
			begin : g_dcp
				assign hit[i] = ~blocked & ~rt.dir[i] & rx_hit;
			end
			else
			begin : g_std
				assign hit[i] = ~blocked & (rt.dir[i] ? tx_hit : rx_hit);
			end
		end
	endgenerate

	always_comb
	begin
		n = s;
		n.trig_reg = hit;
		n.dir_prev_reg = rt.dir;
		n.acl_prev_reg = rt.auto_clr;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			s <= '0;
		else
			s <= n;
	end

	assign rt.trig = s.trig_reg;
endmodule

// *** src/usb_port1_ready_irq.sv ***
// Summary of operation
// - overcurrent pin edge sets overcurrent change flag
// - enabled set flag drives interrupt pin low
// - overcurrent monitor bit mirrors pin level
// - J/K/SE0 line change sets bus flag
// - host: disconnect detection sets detach flag
// - host: J or K held 2.5us sets attach
// - attach only after entering J/K, then held
// - host: traffic at EOF2 sets frame error
// - frame error clears port active, idles port
// - stopped clock: only overcurrent, bus change detected
// - one ready flag per pipe, upper bits zero
// - write zero clears ready flag, one keeps
// - enabled ready flag sets summary, asserts interrupt
// - transmit: direction bit rise triggers ready
// - transmit: packet sent while unwritable triggers
// - double transmit: trigger after one side written while other side empty
// - isochronous transmit: hardware flush triggers ready
// - auto clear enabling writes triggers ready
// - never transmit trigger on default control pipe
// - receive: packet into inaccessible buffer triggers
// - receive: short packet triggers unless PID mismatch
// - receive: transaction count reached triggers
// - double receive: trigger after read completes
// - peripheral: no triggers in status stage
`timescale 1ns/1ps

module usb_port1_ready_irq
	import usb_irq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [`DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [`DATA_W-1:0] rdata,
	input wire logic port1_overcurrent_in,
	input wire logic [1:0] line_state,
	input wire logic disconnect_detect,
	input wire logic eof2_point,
	input wire logic port_traffic_busy,
	input wire logic ctrl_status_stage,
	input wire usb_irq_pkg::pipe_vec_t fifo_access_status,
	input wire usb_irq_pkg::pipe_vec_t tx_pkt_done,
	input wire usb_irq_pkg::pipe_vec_t rx_pkt_done,
	input wire usb_irq_pkg::pipe_vec_t short_pkt,
	input wire usb_irq_pkg::pipe_vec_t trn_count_done,
	input wire usb_irq_pkg::pipe_vec_t pid_mismatch,
	input wire usb_irq_pkg::pipe_vec_t pipe_double,
	input wire usb_irq_pkg::pipe_vec_t pipe_iso,
	input wire usb_irq_pkg::pipe_vec_t iso_flush,
	input wire usb_irq_pkg::pipe_vec_t side_write_done,
	input wire usb_irq_pkg::pipe_vec_t other_side_empty,
	input wire usb_irq_pkg::pipe_vec_t side_read_done,
	input wire usb_irq_pkg::pipe_vec_t other_side_ready,
	output logic irq_b,
	output logic port_active,
	output logic port_idle_req,
	output usb_irq_pkg::pipe_vec_t pipe_direction,
	output usb_irq_pkg::pipe_vec_t auto_buffer_clear
);
	import usb_irq_pkg::*;

	core_state_t s;
	core_state_t n;
	logic [`DATA_W-1:0] port_set;
	logic [`DATA_W-1:0] port_status_word;
	logic [`DATA_W-1:0] main_status_word;
	logic line_moved;
	logic enter_jk;
	logic port_pending;
	logic buffer_ready_pending;
	logic live;
	logic eof_err;
	logic wr_port_irq;
	logic wr_buffer_ready;

	ready_trig_if #(.PIPES(`PIPE_COUNT)) rt ();

	ready_trigger #(.PIPES(`PIPE_COUNT)) u_trigger
	(
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.rt(rt)
	);

	assign rt.dir = s.dir_reg;
	assign rt.end_mode = s.end_mode_reg;
	assign rt.auto_clr = s.auto_clr_reg;
	assign rt.access_ok = fifo_access_status;
	assign rt.tx_done = tx_pkt_done;
	assign rt.rx_done = rx_pkt_done;
	assign rt.short_pkt = short_pkt;
	assign rt.cnt_done = trn_count_done;
	assign rt.pid_mismatch = pid_mismatch;
	assign rt.dbl = pipe_double;
	assign rt.iso = pipe_iso;
	assign rt.iso_flush = iso_flush;
	assign rt.wr_side_done = side_write_done;
	assign rt.other_empty = other_side_empty;
	assign rt.rd_side_done = side_read_done;
	assign rt.other_ready = other_side_ready;
	assign rt.ready_mode = s.ready_mode_reg;
	assign rt.status_stage = ~s.host_mode_reg & ctrl_status_stage;

	// clocked port logic runs only while the clock supply is on
	assign live = s.host_mode_reg & s.clock_supply_enable_reg;
	assign line_moved = line_state != s.line_prev_reg;
	assign enter_jk = line_moved & ((line_state == `LS_J) | (line_state == `LS_K));
	assign eof_err = live & eof2_point & port_traffic_busy;
	assign wr_port_irq = wr_stb & (addr == `OFS_PORT_IRQ);
	assign wr_buffer_ready = wr_stb & (addr == `OFS_BUFFER_READY_STS);

	assign port_pending = |(s.port_irq_reg & s.port_en_reg);
	assign buffer_ready_pending = |(s.buffer_ready_reg & s.buffer_ready_en_reg);

	always_comb
	begin
		port_status_word = `RESET_WORD;
		port_status_word[`PS_LINE_LO +: 2] = line_state;
		port_status_word[`PS_OCMON] = port1_overcurrent_in;
		port_status_word[`PS_ACTIVE] = s.port_active_reg;
		port_status_word[`PS_HOST] = s.host_mode_reg;
		port_status_word[`PS_CLOCK_SUPPLY_ENABLE] = s.clock_supply_enable_reg;
	end

	always_comb
	begin
		main_status_word = `RESET_WORD;
		main_status_word[`MAIN_PORT_BIT] = port_pending;
		main_status_word[`MAIN_BUFFER_READY_BIT] = buffer_ready_pending;
	end

	always_comb
	begin
		port_set = `RESET_WORD;
		// these two stay alive with the clock supply stopped
		port_set[`BIT_OVRC] = port1_overcurrent_in != s.oc_prev_reg;
		port_set[`BIT_BUS_CHANGE_FLAG] = line_moved & (line_state != `LS_SE1)
			& (s.line_prev_reg != `LS_SE1);
		port_set[`BIT_DETACH_FLAG] = live & disconnect_detect;
		port_set[`BIT_EOF] = eof_err;
		if (live && s.att_state_reg == ATT_HOLD && !line_moved
			&& s.att_cnt_reg == `ATT_CNT_W'(`ATTACH_HOLD_CYC - 1))
			port_set[`BIT_ATTACH] = 1'b1;
	end

	always_comb
	begin
		n = s;
		n.oc_prev_reg = port1_overcurrent_in;
		n.line_prev_reg = line_state;

		// attach qualifier: a fresh J or K that must stay put
		if (!live)
		begin
			n.att_state_reg = ATT_IDLE;
			n.att_cnt_reg = '0;
		end
		else
		begin
			case (s.att_state_reg)
				ATT_IDLE:
				begin
					if (enter_jk)
					begin
						n.att_state_reg = ATT_HOLD;
						n.att_cnt_reg = `ATT_CNT_W'(1);
					end
				end
				ATT_HOLD:
				begin
					if (enter_jk)
						n.att_cnt_reg = `ATT_CNT_W'(1);
					else if (line_moved)
						n.att_state_reg = ATT_IDLE;
					else if (s.att_cnt_reg == `ATT_CNT_W'(`ATTACH_HOLD_CYC - 1))
						n.att_state_reg = ATT_DONE;
					else
						n.att_cnt_reg = s.att_cnt_reg + `ATT_CNT_W'(1);
				end
				ATT_DONE:
				begin
					if (enter_jk)
					begin
						n.att_state_reg = ATT_HOLD;
						n.att_cnt_reg = `ATT_CNT_W'(1);
					end
					else if (line_moved)
						n.att_state_reg = ATT_IDLE;
				end
				default:
				begin
					n.att_state_reg = ATT_IDLE;
					n.att_cnt_reg = '0;
				end
			endcase
		end

		// write zero clears, write one keeps; a same-cycle event survives
		if (wr_port_irq)
			n.port_irq_reg = ((s.port_irq_reg & wdata) | port_set) & `PORT_IRQ_MASK;
		else
			n.port_irq_reg = (s.port_irq_reg | port_set) & `PORT_IRQ_MASK;

		if (wr_buffer_ready)
			n.buffer_ready_reg = (s.buffer_ready_reg & wdata[`PIPE_COUNT-1:0]) | rt.trig;
		else
			n.buffer_ready_reg = s.buffer_ready_reg | rt.trig;

		if (wr_stb)
		begin
			case (addr)
				`OFS_PORT_STATUS:
				begin
					n.port_active_reg = wdata[`PS_ACTIVE];
					n.host_mode_reg = wdata[`PS_HOST];
					n.clock_supply_enable_reg = wdata[`PS_CLOCK_SUPPLY_ENABLE];
				end
				`OFS_PIPE_MODE:
					n.ready_mode_reg = wdata[`MODE_READY_FLAG];
				`OFS_PORT_IRQ_EN:
					n.port_en_reg = wdata & `PORT_IRQ_MASK;
				`OFS_BUFFER_READY_EN:
					n.buffer_ready_en_reg = wdata[`PIPE_COUNT-1:0];
				`OFS_PIPE_DIR:
					n.dir_reg = wdata[`PIPE_COUNT-1:0];
				`OFS_END_MODE:
					n.end_mode_reg = wdata[`PIPE_COUNT-1:0];
				`OFS_AUTO_CLR:
					n.auto_clr_reg = wdata[`PIPE_COUNT-1:0];
				default:
				begin
				end
			endcase
		end

		// frame end error overrides any software write of port active
		if (eof_err)
			n.port_active_reg = 1'b0;
		n.idle_pulse_reg = eof_err;

		n.rdata_reg = `RESET_WORD;
		if (rd_stb)
		begin
			case (addr)
				`OFS_PORT_STATUS:
					n.rdata_reg = port_status_word;
				`OFS_PIPE_MODE:
					n.rdata_reg = {{(`DATA_W-1){1'b0}}, s.ready_mode_reg};
				`OFS_PORT_IRQ_EN:
					n.rdata_reg = s.port_en_reg;
				`OFS_BUFFER_READY_EN:
					n.rdata_reg = {{(`DATA_W-`PIPE_COUNT){1'b0}}, s.buffer_ready_en_reg};
				`OFS_MAIN_IRQ:
					n.rdata_reg = main_status_word;
				`OFS_PORT_IRQ:
					n.rdata_reg = s.port_irq_reg;
				`OFS_BUFFER_READY_STS:
					n.rdata_reg = {{(`DATA_W-`PIPE_COUNT){1'b0}}, s.buffer_ready_reg};
				`OFS_PIPE_DIR:
					n.rdata_reg = {{(`DATA_W-`PIPE_COUNT){1'b0}}, s.dir_reg};
				`OFS_END_MODE:
					n.rdata_reg = {{(`DATA_W-`PIPE_COUNT){1'b0}}, s.end_mode_reg};
				`OFS_AUTO_CLR:
					n.rdata_reg = {{(`DATA_W-`PIPE_COUNT){1'b0}}, s.auto_clr_reg};
				default:
					n.rdata_reg = `RESET_WORD;
			endcase
		end

		n.irq_b_reg = ~(port_pending | buffer_ready_pending);
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.irq_b_reg <= 1'b1;
		end
		else
			s <= n;
	end

	assign rdata = s.rdata_reg;
	assign irq_b = s.irq_b_reg;
	assign port_active = s.port_active_reg;
	assign port_idle_req = s.idle_pulse_reg;
	assign pipe_direction = s.dir_reg;
	assign auto_buffer_clear = s.auto_clr_reg;
endmodule

// *** testbench/usb_port_device_model.sv ***
`timescale 1ns/1ps

module usb_port_device_model
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic attached,
	input wire logic fault,
	output logic [1:0] line_state,
	output logic port1_overcurrent_in
);
	// pull-downs give SE0 while detached
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			line_state <= 2'h0;
			port1_overcurrent_in <= 1'b0;
		end
		else
		begin
			line_state <= attached ? 2'h1 : 2'h0;
			port1_overcurrent_in <= fault;
		end
	end
endmodule

// *** testbench/usb_irq_props.sv ***
`timescale 1ns/1ps
`include "usb_port1_ready_irq_regs.svh"

module usb_irq_props
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [`DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [`DATA_W-1:0] rdata,
	input wire logic port1_overcurrent_in,
	input wire logic eof2_point,
	input wire logic port_traffic_busy,
	input wire logic irq_b,
	input wire logic port_active,
	input wire logic port_idle_req
);
	logic [15:0] en_reg;

	// shadow of overcurrent and pipe enables
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			en_reg <= 16'h0000;
		else if (wr_stb && addr == 8'h34)
			en_reg[15] <= wdata[15];
		else if (wr_stb && addr == 8'h36)
			en_reg[9:0] <= wdata[9:0];
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence idle_pulse;
		port_idle_req ##1 !port_idle_req;
	endsequence

	chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
		else $error("read data not zero outside read slot");
	chk_buffer_ready_upper: assert property ($past(rd_stb) && $past(addr) == 8'h46 |-> rdata[15:10] == 6'h00)
		else $error("unassigned ready bits not zero");
	chk_oc_monitor: assert property ($past(rd_stb) && $past(addr) == 8'h04 |-> rdata[2] == $past(port1_overcurrent_in))
		else $error("monitor bit differs from pin");
	chk_oc_irq: assert property ($changed(port1_overcurrent_in) && en_reg[15] |-> ##[1:3] !irq_b)
		else $error("pin change gave no interrupt");
	chk_buffer_ready_irq: assert property ($past(rd_stb) && $past(addr) == 8'h46 && (rdata[9:0] & en_reg[9:0]) != 10'h000 |-> !irq_b)
		else $error("enabled ready flag without interrupt");
	chk_active_drop: assert property ($fell(port_active) && !$past(wr_stb) |-> $past(eof2_point && port_traffic_busy))
		else $error("port active dropped without cause");
	chk_idle_pulse: assert property ($rose(port_idle_req) |-> idle_pulse)
		else $error("idle request not one cycle");
	chk_idle_cause: assert property ($rose(port_idle_req) |-> $past(eof2_point && port_traffic_busy) && !port_active)
		else $error("idle request without frame end error");
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps

module testbench;
	import usb_irq_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, eof2_point = 1'b0, port_traffic_busy = 1'b0;
	logic disconnect_detect = 1'b0, ctrl_status_stage = 1'b0, dev_attached = 1'b0, dev_fault = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata;
	logic [1:0] line_state;
	logic port1_overcurrent_in, irq_b, port_active, port_idle_req;
	pipe_vec_t fifo_access_status = '0, tx_pkt_done = '0, rx_pkt_done = '0, short_pkt = '0, trn_count_done = '0;
	pipe_vec_t pid_mismatch = '0, pipe_double = '0, pipe_iso = '0, iso_flush = '0, side_write_done = '0;
	pipe_vec_t other_side_empty = '0, side_read_done = '0, other_side_ready = '0, pipe_direction, auto_buffer_clear;
	int fails = 0, n_compared = 0;

	usb_port1_ready_irq dut (.*);
	usb_port_device_model dev (.clk_sys(clk_sys), .rst_b(rst_b), .attached(dev_attached), .fault(dev_fault),
		.line_state(line_state), .port1_overcurrent_in(port1_overcurrent_in));

	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string what);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		#1 chk(what, rdata, exp);
		@(posedge clk_sys);
	endtask

	task automatic t_oc;
		rdc(8'h46, 16'h0000, "ready reset");
		wr(8'h34, 16'h8000);
		dev_fault <= 1'b1;
		cyc(4);
		rdc(8'h04, 16'h0004, "monitor");
		rdc(8'h44, 16'h8000, "oc rise");
		#1 chk("irq_b", irq_b, 16'h0000);
		wr(8'h44, 16'h7FFF);
		rdc(8'h44, 16'h0000, "oc cleared");
		dev_fault <= 1'b0;
		cyc(4);
		rdc(8'h44, 16'h8000, "oc fall");
		wr(8'h44, 16'h0000);
		wr(8'h34, 16'h0000);
		$display("test overcurrent done");
	endtask

	task automatic t_attach;
		dev_attached <= 1'b1;
		cyc(80);
		rdc(8'h44, 16'h4000, "stopped clock");
		wr(8'h04, 16'h0420);
		wr(8'h44, 16'h0000);
		dev_attached <= 1'b0;
		cyc(4);
		dev_attached <= 1'b1;
		cyc(40);
		rdc(8'h44, 16'h4000, "attach early");
		cyc(30);
		rdc(8'h44, 16'h4800, "attach held");
		wr(8'h44, 16'h0000);
		disconnect_detect <= 1'b1;
		@(posedge clk_sys);
		disconnect_detect <= 1'b0;
		cyc(2);
		rdc(8'h44, 16'h1000, "detach");
		wr(8'h44, 16'h0000);
		$display("test attach done");
	endtask

	task automatic t_eof;
		wr(8'h04, 16'h0430);
		eof2_point <= 1'b1;
		port_traffic_busy <= 1'b1;
		@(posedge clk_sys);
		eof2_point <= 1'b0;
		port_traffic_busy <= 1'b0;
		#1 chk("idle req", port_idle_req, 16'h0001);
		cyc(3);
		rdc(8'h04, 16'h0421, "active cleared");
		rdc(8'h44, 16'h0040, "frame end error");
		wr(8'h44, 16'h0000);
		$display("test frame end done");
	endtask

	task automatic t_buffer_ready;
		wr(8'h36, 16'h03FF);
		wr(8'h50, 16'h0009);
		cyc(3);
		chk("pipe dir", {6'h00, pipe_direction}, 16'h0009);
		rdc(8'h46, 16'h0008, "dir rise");
		rdc(8'h40, 16'h0100, "summary");
		#1 chk("irq_b", irq_b, 16'h0000);
		wr(8'h46, 16'hFFFE);
		rdc(8'h46, 16'h0008, "one keeps");
		wr(8'h46, 16'h0000);
		rdc(8'h46, 16'h0000, "zero clears");
		tx_pkt_done <= 10'h009;
		@(posedge clk_sys);
		tx_pkt_done <= '0;
		wr(8'h46, 16'hFFF7);
		rdc(8'h46, 16'h0008, "set beats clear");
		fifo_access_status <= 10'h040;
		rx_pkt_done <= 10'h060;
		pid_mismatch <= 10'h020;
		short_pkt <= 10'h040;
		@(posedge clk_sys);
		rx_pkt_done <= '0;
		pid_mismatch <= '0;
		short_pkt <= '0;
		cyc(3);
		rdc(8'h46, 16'h0048, "receive");
		// software clears the flags before touching the buffer
		wr(8'h46, 16'hFC00);
		rdc(8'h46, 16'h0000, "all cleared");
		wr(8'h54, 16'h0008);
		cyc(3);
		chk("auto clear", {6'h00, auto_buffer_clear}, 16'h0008);
		rdc(8'h46, 16'h0008, "auto clear trigger");
		$display("test ready done");
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_oc;
		t_attach;
		t_eof;
		t_buffer_ready;
		wrap_up;
	end

	// run needs about 275 cycles
	initial
	begin
		#100000;
		fails++;
		wrap_up;
	end
endmodule

bind usb_port1_ready_irq usb_irq_props props (.*);
